// file: verilog/ptw_top.sv
// Purpose: Periodic tick, watchdog and clock-monitor reset control
// Assumes: AHB-Lite slave, zero wait states, mode inputs synchronous
// Notes:   Slow clock is an enable pulse divided from clk
`timescale 1ns/1ps
`default_nettype none
`include "ptw_regs.svh"

module ptw_top
    import ptw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        special_mode,
    input  wire logic        wait_mode,
    input  wire logic        debug_mode,
    input  wire logic        clock_fail,
    output logic             tick_irq,
    output logic             monitor_active,
    output logic             wd_reset,
    output logic             clkmon_reset
);

    ptw_tick_ctrl_t              tick_ctrl;
    ptw_wd_ctrl_t                wd_ctrl;
    ptw_svc_t                    svc_state;
    logic                        tick_flag;
    logic                        tick_once_done;
    logic                        wd_once_done;
    logic                        dp_wr;
    logic [7:0]                  dp_idx;
    logic [1:0]                  xdiv;
    logic [`PTW_PRE_W-1:0]       pre;
    logic [`PTW_STAGE_W-1:0]     stage;
    logic [`PTW_STAGE_W-1:0]     wd_cnt;

    // Bus decode
    wire         addr_ok    = haddr[1:0] == 2'b00 && haddr[31:10] == 22'h0;
    wire  [7:0]  a_idx      = haddr[9:2];
    wire         ap_valid   = hsel & htrans[1] & hready;
    wire  [7:0]  wdat       = hwdata[7:0];
    wire         wr_tctl    = dp_wr && dp_idx == `PTW_IDX_TICK_CTRL;
    wire         wr_tflg    = dp_wr && dp_idx == `PTW_IDX_TICK_FLAG;
    wire         wr_wctl    = dp_wr && dp_idx == `PTW_IDX_WD_CTRL;
    wire         wr_svc     = dp_wr && dp_idx == `PTW_IDX_WD_SERVICE;

    // Read mux
    wire  [7:0]  rd_byte    =
        (a_idx == `PTW_IDX_TICK_CTRL) ? tick_ctrl :
        (a_idx == `PTW_IDX_TICK_FLAG) ? {tick_flag, 7'h00} :
        (a_idx == `PTW_IDX_WD_CTRL)   ? wd_ctrl : 8'h00;

    // Halt and slow clock enable
    wire         halted     = (wait_mode & tick_ctrl.halt_in_wait)
                            | (debug_mode & tick_ctrl.halt_in_debug);
    wire         slow_clock_en    = xdiv == 2'(`PTW_SLOW_CLOCK_DIV - 1);
    wire         run        = slow_clock_en & ~halted;

    // Shared prescaler
    wire         pre_tick   = run & (tick_ctrl.divider_bypass
                            ? (pre & `PTW_BYPASS_MASK) == `PTW_BYPASS_MASK
                            : &pre);

    // Tick tap select
    wire  [2:0]  trate      = tick_ctrl.tick_rate_sel;
    wire  [5:0]  tmask      = 6'((7'h1 << (trate - 3'd1)) - 7'h1);
    wire         tick_hit   = pre_tick && trate != 3'd0
                            && (stage[5:0] & tmask) == tmask;

    // Watchdog limit in prescaler periods
    wire  [2:0]  wrate      = wd_ctrl.watchdog_rate_sel;
    wire  [10:0] wlim       =
        (wrate == 3'd1) ? 11'h001 : (wrate == 3'd2) ? 11'h004 :
        (wrate == 3'd3) ? 11'h010 : (wrate == 3'd4) ? 11'h040 :
        (wrate == 3'd5) ? 11'h100 : (wrate == 3'd6) ? 11'h200 :
        11'h400;
    wire         wd_on      = wrate != 3'd0;
    wire  [10:0] wcnt_x     = {1'b0, wd_cnt};
    wire         wd_timeout = wd_on && pre_tick
                            && wcnt_x >= wlim - 11'h001;
    wire         win_open   = wcnt_x >= wlim - (wlim >> 2);

    // Service decode
    wire         key1       = wdat == `PTW_KEY_FIRST;
    wire         key2       = wdat == `PTW_KEY_SECOND;
    wire         svc_bad    = wr_svc & wd_on & ~key1 & ~key2;
    wire         svc_early  = wr_svc & wd_on & wd_ctrl.window_mode
                            & ~win_open;
    wire         svc_done   = wr_svc & wd_on & key2
                            & (svc_state == PTW_SVC_ARMED);
    wire         svc_restart = svc_done & ~svc_early;

    // Reset sources
    wire         dis        = wd_ctrl.reset_disable;
    wire         mon_on     = wd_ctrl.monitor_enable
                            | wd_ctrl.force_monitor;
    wire         ff_wd      = wd_ctrl.forced_failure & wd_on;
    wire         ff_cm      = wd_ctrl.forced_failure
                            & wd_ctrl.monitor_enable;
    wire         cm_fire    = ~dis & ((mon_on & clock_fail) | ff_cm);
    wire         wd_fire    = ~dis & ~cm_fire
                            & (wd_timeout | svc_bad | svc_early | ff_wd);

    // Write masks
    wire         tick_once_ok = special_mode | ~tick_once_done;
    wire         wd_once_ok   = special_mode | ~wd_once_done;
    ptw_tick_ctrl_t next_tick_ctrl;
    ptw_wd_ctrl_t   next_wd_ctrl;
    ptw_tick_ctrl_t tw;
    ptw_wd_ctrl_t   ww;
    assign tw = wdat;
    assign ww = wdat;

    always_comb begin
        next_tick_ctrl = tick_ctrl;
        next_wd_ctrl   = wd_ctrl;
        if (wr_tctl) begin
            next_tick_ctrl.tick_irq_enable = tw.tick_irq_enable;
            next_tick_ctrl.tick_rate_sel   = tw.tick_rate_sel;
            if (tick_once_ok) begin
                next_tick_ctrl.halt_in_wait  = tw.halt_in_wait;
                next_tick_ctrl.halt_in_debug = tw.halt_in_debug;
            end
            if (special_mode) begin
                next_tick_ctrl.divider_bypass = tw.divider_bypass;
            end
        end
        if (wr_wctl) begin
            next_wd_ctrl.monitor_enable = ww.monitor_enable;
            if (wd_once_ok) begin
                next_wd_ctrl.force_monitor     = ww.force_monitor;
                next_wd_ctrl.window_mode       = ww.window_mode;
                next_wd_ctrl.watchdog_rate_sel = ww.watchdog_rate_sel;
            end
            if (special_mode) begin
                next_wd_ctrl.forced_failure = ww.forced_failure;
                next_wd_ctrl.reset_disable  = ww.reset_disable;
            end
        end
    end

    // Bus slave
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dp_wr     <= 1'b0;
            dp_idx    <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            dp_wr     <= ap_valid & hwrite & addr_ok & hsize == 3'b010;
            dp_idx    <= a_idx;
            hrdata    <= (ap_valid & ~hwrite & addr_ok)
                         ? {24'h0, rd_byte} : 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Control registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_ctrl      <= `PTW_TICK_CTRL_RST;
            wd_ctrl        <= special_mode ? `PTW_WD_CTRL_RST_SPEC
                                           : `PTW_WD_CTRL_RST_NORM;
            tick_once_done <= 1'b0;
            wd_once_done   <= 1'b0;
        end else begin
            tick_ctrl      <= next_tick_ctrl;
            wd_ctrl        <= next_wd_ctrl;
            tick_once_done <= tick_once_done | wr_tctl;
            wd_once_done   <= wd_once_done | wr_wctl;
        end
    end

    // Counter chain
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            xdiv   <= 2'd0;
            pre    <= '0;
            stage  <= '0;
            wd_cnt <= '0;
        end else begin
            xdiv <= slow_clock_en ? 2'd0 : xdiv + 2'd1;
            if (run) begin
                pre <= pre + 1'b1;
            end
            if (pre_tick) begin
                stage <= stage + 1'b1;
            end
            if (svc_restart || !wd_on) begin
                wd_cnt <= '0;
            end else if (pre_tick) begin
                wd_cnt <= wd_timeout ? '0 : wd_cnt + 1'b1;
            end
        end
    end

    // Tick flag, service state and outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_flag      <= 1'b0;
            svc_state      <= PTW_SVC_IDLE;
            tick_irq       <= 1'b0;
            monitor_active <= 1'b0;
            wd_reset       <= 1'b0;
            clkmon_reset   <= 1'b0;
        end else begin
            tick_flag <= tick_hit | (tick_flag
                & ~(wr_tflg & wdat[`PTW_BIT_TICK_FLAG]));
            case (svc_state)
                PTW_SVC_IDLE: begin
                    if (wr_svc && key1) begin
                        svc_state <= PTW_SVC_ARMED;
                    end
                end
                PTW_SVC_ARMED: begin
                    if (svc_done) begin
                        svc_state <= PTW_SVC_IDLE;
                    end
                end
                default: svc_state <= PTW_SVC_IDLE;
            endcase
            tick_irq       <= tick_ctrl.tick_irq_enable & tick_flag;
            monitor_active <= mon_on;
            wd_reset       <= wd_reset | wd_fire;
            clkmon_reset   <= clkmon_reset | cm_fire;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_flag_enabled;
        tick_flag && tick_ctrl.tick_irq_enable;
    endsequence

    property p_irq;
        s_flag_enabled |=> tick_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_irq_off;
        !tick_ctrl.tick_irq_enable |=> !tick_irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("irq while disabled");

    property p_halt_wait;
        wait_mode && tick_ctrl.halt_in_wait |=> $stable(pre) && $stable(stage);
    endproperty
    a_halt_wait: assert property (p_halt_wait)
        else $error("counting in wait");

    property p_halt_dbg;
        debug_mode && tick_ctrl.halt_in_debug |=> $stable(pre);
    endproperty
    a_halt_dbg: assert property (p_halt_dbg)
        else $error("counting in debug");

    property p_once;
        !special_mode && tick_once_done |=> $stable(tick_ctrl.halt_in_wait);
    endproperty
    a_once: assert property (p_once)
        else $error("second write accepted");

    property p_bypass;
        !special_mode |=> $stable(tick_ctrl.divider_bypass);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass written in normal");

    property p_flag_set;
        tick_hit |=> tick_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("tick flag lost");

    property p_force_mon;
        !special_mode && wd_ctrl.force_monitor |=> ##1 monitor_active;
    endproperty
    a_force_mon: assert property (p_force_mon)
        else $error("monitor dropped");

    property p_bad_key;
        svc_bad && !dis && !cm_fire |=> wd_reset;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("bad key ignored");

    property p_timeout;
        wd_timeout && !dis |=> wd_reset || clkmon_reset;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("time-out ignored");

    property p_disable;
        $rose(wd_reset) || $rose(clkmon_reset) |-> !$past(dis);
    endproperty
    a_disable: assert property (p_disable)
        else $error("reset while disabled");

    property p_both;
        ff_wd && ff_cm && !dis && !wd_reset |=> clkmon_reset && !wd_reset;
    endproperty
    a_both: assert property (p_both)
        else $error("both resets serviced");

endmodule : ptw_top
`default_nettype wire

// file: verilog/ptw_regs.svh
// Purpose: Register map, field positions, reset values and counts
// Assumes: 32-bit AHB-Lite word per register
// Notes:   Byte address is four times the register index
`ifndef PTW_REGS_SVH
`define PTW_REGS_SVH

`define PTW_IDX_TICK_CTRL    8'h14
`define PTW_IDX_TICK_FLAG    8'h15
`define PTW_IDX_WD_CTRL      8'h16
`define PTW_IDX_WD_SERVICE   8'h17

`define PTW_BIT_TICK_FLAG    7

`define PTW_WD_CTRL_RST_NORM 8'h07
`define PTW_WD_CTRL_RST_SPEC 8'h0f
`define PTW_TICK_CTRL_RST    8'h00

`define PTW_KEY_FIRST        8'h55
`define PTW_KEY_SECOND       8'haa

`define PTW_SLOW_CLOCK_DIV         2
`define PTW_PRE_W            13
`define PTW_STAGE_W          10
`define PTW_BYPASS_MASK      13'h0003

`endif

// file: verilog/ptw_pkg.sv
// Purpose: Types for the periodic tick and watchdog block
// Assumes: Field layouts match the register header
// Notes:   Register images are packed structs
package ptw_pkg;

    typedef struct packed {
        logic       tick_irq_enable;
        logic       halt_in_wait;
        logic       halt_in_debug;
        logic       divider_bypass;
        logic       reserved;
        logic [2:0] tick_rate_sel;
    } ptw_tick_ctrl_t;

    typedef struct packed {
        logic       monitor_enable;
        logic       force_monitor;
        logic       forced_failure;
        logic       window_mode;
        logic       reset_disable;
        logic [2:0] watchdog_rate_sel;
    } ptw_wd_ctrl_t;

    typedef enum logic [1:0] {
        PTW_SVC_IDLE  = 2'b00,
        PTW_SVC_ARMED = 2'b01
    } ptw_svc_t;

endpackage : ptw_pkg

// file: verification/tb_top.sv
// Purpose: Self-checking bench for the tick and watchdog block
// Assumes: Zero-wait AHB-Lite slave, bypass divider in special mode
// Notes:   Reads are checked by a monitor against a queue of notes
`timescale 1ns/1ps
`default_nettype none
`include "ptw_regs.svh"

module tb_top;
    localparam logic [31:0] A_TC = {22'h0, `PTW_IDX_TICK_CTRL, 2'b00};
    localparam logic [31:0] A_TF = {22'h0, `PTW_IDX_TICK_FLAG, 2'b00};
    localparam logic [31:0] A_WC = {22'h0, `PTW_IDX_WD_CTRL, 2'b00};
    localparam logic [31:0] A_WS = {22'h0, `PTW_IDX_WD_SERVICE, 2'b00};

    logic        clk          = 1'b0;
    logic        sys_rst      = 1'b1;
    logic        hsel         = 1'b0;
    logic        hwrite       = 1'b0;
    logic        special_mode = 1'b0;
    logic        wait_mode    = 1'b0;
    logic        debug_mode   = 1'b0;
    logic        clock_fail   = 1'b0;
    logic [31:0] haddr        = 32'h0;
    logic [31:0] hwdata       = 32'h0;
    logic [1:0]  htrans       = 2'h0;
    logic [2:0]  hsize        = 3'h2;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        tick_irq;
    logic        monitor_active;
    logic        wd_reset;
    logic        clkmon_reset;
    logic        rd_pend      = 1'b0;
    logic [31:0] exp_q[$];
    int          n_fail       = 0;
    int          check_count  = 0;
    int          seed         = 32'h98a1;
    int          cyc          = 0;
    int          t0;
    logic [7:0]  bad;

    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    ptw_top ptw_top_inst (
        .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .special_mode(special_mode), .wait_mode(wait_mode),
        .debug_mode(debug_mode), .clock_fail(clock_fail),
        .tick_irq(tick_irq), .monitor_active(monitor_active),
        .wd_reset(wd_reset), .clkmon_reset(clkmon_reset)
    );

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t %s is %b", $time, what, got);
        end
    endtask : chk_bit

    // Read data monitor: data phase follows a taken read address phase
    always @(posedge clk) begin
        if (rd_pend && hreadyout === 1'b1) begin
            if (exp_q.size() > 0) chk_val(hrdata, exp_q.pop_front());
            chk_bit(hresp, 1'b0, "hresp");
        end
        rd_pend <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
    end

    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        xfer(a, 1'b0, 32'h0);
    endtask : rd

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_n

    task automatic wait_irq(input int n);
        for (int i = 0; i < n && tick_irq !== 1'b1; i++) @(posedge clk);
    endtask : wait_irq

    task automatic clr_flag();
        wr(A_TF, 32'h80);
        wait_n(2);
    endtask : clr_flag

    task automatic do_reset(input logic mode);
        @(posedge clk);
        sys_rst      <= 1'b1;
        special_mode <= mode;
        wait_n(10);
        sys_rst <= 1'b0;
        @(posedge clk);
        if (mode) wr(A_TC, 32'h10);
    endtask : do_reset

    task automatic print_verdict();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    initial begin
        #(60000 * 100);
        n_fail++;
        print_verdict();
    end

    initial begin
        wait_n(10);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(A_TC, 32'h00);
        rd(A_TF, 32'h00);
        rd(A_WC, 32'h07);
        rd(A_WS, 32'h00);
        rd(32'h40, 32'h00);
        clock_fail <= 1'b1;
        wait_n(5);
        chk_bit(clkmon_reset, 1'b0, "clkmon");
        wr(A_TC, 32'hf1);
        rd(A_TC, 32'he1);
        wr(A_TC, 32'h01);
        rd(A_TC, 32'h61);
        wr(A_WC, 32'heb);
        rd(A_WC, 32'hc3);
        wr(A_WC, 32'h04);
        rd(A_WC, 32'h43);
        wait_n(5);
        chk_bit(monitor_active, 1'b1, "monitor");
        chk_bit(clkmon_reset, 1'b1, "clkmon");
        clock_fail <= 1'b0;
        do_reset(1'b1);
        rd(A_WC, 32'h1f & 32'h0f);
        for (int r = 2; r < 8; r++) begin
            wr(A_TC, 32'h90 | r);
            clr_flag();
            wait_irq(1200);
            t0 = cyc;
            clr_flag();
            wait_irq(1200);
            chk_val(32'(cyc - t0), 32'(8 << (r - 1)));
        end
        rd(A_TF, 32'h80);
        wr(A_TC, 32'h17);
        clr_flag();
        chk_bit(tick_irq, 1'b0, "irq");
        wait_n(600);
        chk_bit(tick_irq, 1'b0, "irq");
        rd(A_TF, 32'h80);
        wait_mode <= 1'b1;
        wr(A_TC, 32'hf7);
        clr_flag();
        wait_n(1100);
        chk_bit(tick_irq, 1'b0, "irq");
        wait_mode  <= 1'b0;
        debug_mode <= 1'b1;
        wait_n(1100);
        chk_bit(tick_irq, 1'b0, "irq");
        debug_mode <= 1'b0;
        wait_irq(600);
        chk_bit(tick_irq, 1'b1, "irq");
        wr(A_TC, 32'h10);
        wr(A_WC, 32'h00);
        wr(A_WC, 32'h02);
        wait_n(16);
        chk_bit(wd_reset, 1'b0, "wd early");
        wait_n(40);
        chk_bit(wd_reset, 1'b1, "wd timeout");
        do_reset(1'b1);
        wr(A_WC, 32'h07);
        repeat (3) begin
            wait_n(($random(seed) & 15) + 1);
            wr(A_WS, 32'h55);
            wr(A_WS, 32'h55);
            wr(A_WS, 32'haa);
        end
        chk_bit(wd_reset, 1'b0, "wd service");
        bad = 8'($random(seed)) | 8'h01;
        if (bad == 8'h55) bad = 8'h57;
        wr(A_WS, {24'h0, bad});
        wait_n(3);
        chk_bit(wd_reset, 1'b1, "wd bad key");
        do_reset(1'b1);
        wr(A_WS, 32'h33);
        wr(A_WC, 32'h2f);
        wait_n(3);
        chk_bit(wd_reset, 1'b0, "wd disabled");
        wr(A_WC, 32'h17);
        wr(A_WS, 32'h55);
        wait_n(3);
        chk_bit(wd_reset, 1'b1, "wd window");
        do_reset(1'b1);
        wr(A_WC, 32'ha7);
        wait_n(3);
        chk_bit(clkmon_reset, 1'b1, "forced clkmon");
        chk_bit(wd_reset, 1'b0, "forced wd");
        do_reset(1'b1);
        wr(A_WC, 32'h27);
        wait_n(3);
        chk_bit(wd_reset, 1'b1, "forced wd");
        wait_n(3);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
